// *** core/sec_counter.sv ***
// sec_counter: two 32-bit seconds counters behind a three-wire port.
// assumes port pins are asynchronous and far slower than clk_i.
`timescale 1ns/1ps
`default_nettype none
module sec_counter #(
  parameter int unsigned SEC_CYCLES = sec_pkg::CYC_PER_SEC,
  parameter int unsigned TRIM_STEP  = sec_pkg::TRIM_STEP_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // three-wire serial port
  input  wire logic port_sel_i,
  input  wire logic sclk_i,
  input  wire logic dq_i,
  output logic      dq_o,
  output logic      dq_oe_o,
  // supply monitor: high while main supply above trip threshold
  input  wire logic supply_ok_i
);

  // pacer needs room for the whole trim range
  if (SEC_CYCLES <= 8 * TRIM_STEP + 2) begin : g_bad_cfg
    $error("sec_counter: SEC_CYCLES too small for trim range");
  end

  // synchronisers: first stage read only by second
  logic psel_m, psel_s, psel_d;
  logic sclk_m, sclk_s, sclk_d;
  logic dq_m, dq_s;
  logic sup_m, sup_s;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      psel_m <= 1'b0;
      psel_s <= 1'b0;
      psel_d <= 1'b0;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      dq_m   <= 1'b0;
      dq_s   <= 1'b0;
      sup_m  <= 1'b0;
      sup_s  <= 1'b0;
    end else begin
      psel_m <= port_sel_i;
      psel_s <= psel_m;
      psel_d <= psel_s;
      sclk_m <= sclk_i;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      dq_m   <= dq_i;
      dq_s   <= dq_m;
      sup_m  <= supply_ok_i;
      sup_s  <= sup_m;
    end
  end

  logic psel_rise, psel_fall, sclk_rise, sclk_fall, xfer_ok;
  assign psel_rise = psel_s & ~psel_d;
  assign psel_fall = ~psel_s & psel_d;
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  // port live only with supply, select held, not on the opening edge
  assign xfer_ok   = sup_s & psel_s & ~psel_rise;

  // seconds pacer
  sec_tick_if tk ();
  sec_tick_gen #(
    .SEC_CYCLES (SEC_CYCLES),
    .TRIM_STEP  (TRIM_STEP)
  ) u_tick (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tk     (tk)
  );

  // registers
  sec_pkg::sec_state_t      state_r;
  logic [7:0]               command_byte_r;
  logic [2:0]               oscillator_trim_r;
  logic [31:0]              always_on_seconds_r;
  logic [31:0]              powered_seconds_r;
  logic [31:0]              hold_r;
  logic [31:0]              wbuf_r;
  logic [sec_pkg::BCNT_W-1:0] bcnt_r;
  logic                     sel_ao_r;
  logic                     clr_ao_r;
  logic                     clr_pw_r;
  logic                     rd_valid_r;
  logic                     dq_r;
  logic                     dq_oe_r;

  assign tk.trim = oscillator_trim_r;

  // command decode on the eighth rise
  logic [7:0]  cmd_full;
  logic        cmd_done;
  logic        sel_ao, sel_pw, is_trim, is_clear, is_read;
  logic [31:0] wdata;
  logic        wr_done;

  assign cmd_full = {dq_s, command_byte_r[7:1]};
  assign cmd_done = xfer_ok & sclk_rise & (state_r == sec_pkg::SEC_CMD)
                  & (bcnt_r == sec_pkg::CMD_LAST);
  assign sel_ao   = cmd_full[sec_pkg::CMD_SEL_AO];
  assign sel_pw   = cmd_full[sec_pkg::CMD_SEL_PW];
  assign is_trim  = sel_ao & sel_pw;
  assign is_clear = ~sel_ao & ~sel_pw;
  assign is_read  = cmd_full[sec_pkg::CMD_READ];
  assign wdata    = {dq_s, wbuf_r[31:1]};
  assign wr_done  = xfer_ok & sclk_rise & (state_r == sec_pkg::SEC_WRITE)
                  & (bcnt_r == sec_pkg::DATA_LAST);

  // transfer state and bit count
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= sec_pkg::SEC_IDLE;
      bcnt_r  <= '0;
    end else if (!sup_s) begin
      state_r <= sec_pkg::SEC_IDLE;
      bcnt_r  <= '0;
    end else if (psel_rise) begin
      state_r <= sec_pkg::SEC_CMD;
      bcnt_r  <= '0;
    end else if (!psel_s) begin
      state_r <= sec_pkg::SEC_IDLE;
      bcnt_r  <= '0;
    end else if (sclk_rise) begin
      unique case (state_r)
        sec_pkg::SEC_IDLE: begin
          state_r <= sec_pkg::SEC_IDLE;
        end
        sec_pkg::SEC_CMD: begin
          if (bcnt_r == sec_pkg::CMD_LAST) begin
            bcnt_r <= '0;
            if (is_trim || is_clear)
              state_r <= sec_pkg::SEC_IGNORE;
            else if (is_read)
              state_r <= sec_pkg::SEC_READ;
            else
              state_r <= sec_pkg::SEC_WRITE;
          end else begin
            bcnt_r <= bcnt_r + 6'h01;
          end
        end
        sec_pkg::SEC_READ, sec_pkg::SEC_WRITE: begin
          if (bcnt_r == sec_pkg::DATA_LAST)
            state_r <= sec_pkg::SEC_IGNORE;
          else
            bcnt_r <= bcnt_r + 6'h01;
        end
        sec_pkg::SEC_IGNORE: begin
          state_r <= sec_pkg::SEC_IGNORE;
        end
      endcase
    end
  end

  // command shift register, sampled on serial rises, lsb first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      command_byte_r <= sec_pkg::CMD_RST;
    else if (xfer_ok && sclk_rise && state_r == sec_pkg::SEC_CMD)
      command_byte_r <= cmd_full;
  end

  // trim register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      oscillator_trim_r <= sec_pkg::TRIM_RST;
    else if (cmd_done && is_trim)
      oscillator_trim_r <= cmd_full[sec_pkg::CMD_TRIM_HI:
                                    sec_pkg::CMD_TRIM_LO];
  end

  // counter select and pending clears, armed by the command
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_ao_r <= 1'b0;
      clr_ao_r <= 1'b0;
      clr_pw_r <= 1'b0;
    end else if (!sup_s || psel_rise) begin
      clr_ao_r <= 1'b0;
      clr_pw_r <= 1'b0;
    end else if (cmd_done) begin
      sel_ao_r <= sel_ao;
      // clears act only for the clear command form
      clr_ao_r <= is_clear & cmd_full[sec_pkg::CMD_CLR_AO];
      clr_pw_r <= is_clear & cmd_full[sec_pkg::CMD_CLR_PW];
    end else if (psel_fall) begin
      clr_ao_r <= 1'b0;
      clr_pw_r <= 1'b0;
    end
  end

  logic ao_clr, pw_clr, ao_wr, pw_wr;
  assign ao_clr = psel_fall & sup_s & clr_ao_r;
  assign pw_clr = psel_fall & sup_s & clr_pw_r;
  assign ao_wr  = wr_done & sel_ao_r;
  assign pw_wr  = wr_done & ~sel_ao_r;

  // write buffer: bits gathered, counter untouched until the last
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      wbuf_r <= sec_pkg::CNT_RST;
    else if (xfer_ok && sclk_rise && state_r == sec_pkg::SEC_WRITE)
      wbuf_r <= wdata;
  end

  // always-on counter; a host load wins over a tick
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      always_on_seconds_r <= sec_pkg::CNT_RST;
    else if (ao_clr)
      always_on_seconds_r <= sec_pkg::CNT_RST;
    else if (ao_wr)
      always_on_seconds_r <= wdata;
    else if (tk.tick)
      always_on_seconds_r <= always_on_seconds_r + 32'h0000_0001;
  end

  // powered counter: holds its count while supply is away
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      powered_seconds_r <= sec_pkg::CNT_RST;
    else if (pw_clr)
      powered_seconds_r <= sec_pkg::CNT_RST;
    else if (pw_wr)
      powered_seconds_r <= wdata;
    else if (tk.tick && sup_s)
      powered_seconds_r <= powered_seconds_r + 32'h0000_0001;
  end

  // read holding register: snapshot avoids a count landing mid-read
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_r     <= sec_pkg::CNT_RST;
      rd_valid_r <= 1'b0;
      dq_r       <= 1'b0;
    end else if (cmd_done && is_read && !is_trim && !is_clear) begin
      hold_r     <= sel_ao ? always_on_seconds_r
                           : powered_seconds_r;
      rd_valid_r <= 1'b0;
    end else if (state_r != sec_pkg::SEC_READ || !xfer_ok) begin
      rd_valid_r <= 1'b0;
    end else if (sclk_fall) begin
      dq_r       <= hold_r[0];
      hold_r     <= {1'b0, hold_r[31:1]};
      rd_valid_r <= 1'b1;
    end
  end

  // drive only in the low half of the serial clock
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      dq_oe_r <= 1'b0;
    else
      dq_oe_r <= (state_r == sec_pkg::SEC_READ) & rd_valid_r
               & ~sclk_s & xfer_ok;
  end

  assign dq_o    = dq_r;
  assign dq_oe_o = dq_oe_r;

  // checks
  a_port_off_quiet:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!sup_s ##1 !sup_s) |=> !dq_oe_r)
    else $error("data line driven with supply down");

  a_select_restart:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (psel_rise && sup_s) |=>
        (state_r == sec_pkg::SEC_CMD && bcnt_r == '0))
    else $error("select rise did not restart command phase");

  a_trim_load:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (cmd_done && is_trim) |=>
        (oscillator_trim_r == $past(cmd_full[5:3]) &&
         state_r == sec_pkg::SEC_IGNORE))
    else $error("trim not loaded from command bits");

  a_hold_snap:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (cmd_done && is_read && !is_trim && !is_clear && sel_ao) |=>
        (hold_r == $past(always_on_seconds_r)))
    else $error("read snapshot wrong");

  a_write_load:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (ao_wr && !ao_clr) |=>
        (always_on_seconds_r == $past(wdata) &&
         state_r == sec_pkg::SEC_IGNORE))
    else $error("write data not loaded whole");

  a_clear_both:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (psel_fall && sup_s && clr_ao_r && clr_pw_r) |=>
        (always_on_seconds_r == '0 && powered_seconds_r == '0))
    else $error("clear on select fall missed");

  a_powered_hold:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      !sup_s |=> (powered_seconds_r == $past(powered_seconds_r)))
    else $error("powered counter moved without supply");

  a_always_on_tick:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (tk.tick && !ao_wr && !ao_clr) |=>
        (always_on_seconds_r ==
         $past(always_on_seconds_r) + 32'h0000_0001))
    else $error("always-on counter missed a tick");

  a_drive_low_half:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      dq_oe_r |-> ($past(!sclk_s) && $past(state_r) ==
                   sec_pkg::SEC_READ))
    else $error("data driven outside read low half");

  a_release_dq:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      !psel_s |=> ##1 !dq_oe_r)
    else $error("data line held after select low");

  a_read_on_fall:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (dq_r != $past(dq_r)) |-> $past(sclk_fall))
    else $error("read data changed off a serial fall");

  a_ignore_rest:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (state_r == sec_pkg::SEC_IGNORE && psel_s && sup_s) |=>
        (state_r == sec_pkg::SEC_IGNORE))
    else $error("clocks after transfer end not ignored");

endmodule
`default_nettype wire

// *** core/sec_pkg.sv ***
// sec_pkg: shared constants of the serial elapsed seconds counter.
// assumes a 25 MHz system clock and a host-driven three-wire port.
package sec_pkg;

  // system clock and seconds pacing
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned TICK_HZ     = 1;
  localparam int unsigned CYC_PER_SEC = CLK_HZ / TICK_HZ;
  // cycles one trim step moves the second; arbitrary plain default
  localparam int unsigned TRIM_STEP_CYC = 40;

  // transfer lengths
  localparam int unsigned CMD_BITS  = 8;
  localparam int unsigned DATA_BITS = 32;
  localparam int unsigned BCNT_W    = 6;
  localparam logic [BCNT_W-1:0] CMD_LAST  = 6'h07;
  localparam logic [BCNT_W-1:0] DATA_LAST = 6'h1F;

  // command byte field positions
  localparam int unsigned CMD_SEL_AO  = 7;
  localparam int unsigned CMD_SEL_PW  = 6;
  localparam int unsigned CMD_TRIM_HI = 5;
  localparam int unsigned CMD_TRIM_LO = 3;
  localparam int unsigned CMD_CLR_AO  = 2;
  localparam int unsigned CMD_CLR_PW  = 1;
  localparam int unsigned CMD_READ    = 0;

  // trim codes and reset values
  localparam logic [2:0]  TRIM_NOMINAL = 3'h3;
  localparam logic [2:0]  TRIM_STOP    = 3'h0;
  localparam logic [2:0]  TRIM_RST     = 3'h3;
  localparam logic [7:0]  CMD_RST      = 8'h00;
  localparam logic [31:0] CNT_RST      = 32'h0000_0000;

  typedef enum logic [2:0] {
    SEC_IDLE,
    SEC_CMD,
    SEC_READ,
    SEC_WRITE,
    SEC_IGNORE
  } sec_state_t;

endpackage

// *** core/sec_tick_gen.sv ***
// sec_tick_gen: one-second tick pacer with trimmable period.
// assumes the trim code is a registered level on the system clock.
`timescale 1ns/1ps
`default_nettype none
module sec_tick_gen #(
  parameter int unsigned SEC_CYCLES = sec_pkg::CYC_PER_SEC,
  parameter int unsigned TRIM_STEP  = sec_pkg::TRIM_STEP_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // trim in, tick out
  sec_tick_if.gen   tk
);

  // refused at elaboration: shortest trimmed second must stay positive
  if (SEC_CYCLES <= 8 * TRIM_STEP + 2) begin : g_bad_cfg
    $error("sec_tick_gen: SEC_CYCLES too small for trim range");
  end

  logic [31:0] div_r;
  logic [31:0] period;
  logic        tick_r;

  // higher code shortens the second, so counting runs faster
  always_comb begin
    period = 32'(SEC_CYCLES) + 32'(TRIM_STEP) * 32'(sec_pkg::TRIM_NOMINAL)
           - 32'(TRIM_STEP) * 32'(tk.trim);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (tk.trim == sec_pkg::TRIM_STOP) begin
      // oscillator stopped: phase held, no ticks
      tick_r <= 1'b0;
    end else if (div_r >= period - 32'h0000_0001) begin
      div_r  <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  assign tk.tick = tick_r;

  a_trim_stop_quiet:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
      (tk.trim == sec_pkg::TRIM_STOP) |=> !tick_r)
    else $error("tick seen while oscillator stopped");

endmodule
`default_nettype wire

// *** core/sec_tick_if.sv ***
// sec_tick_if: trim code out to the seconds pacer, tick back.
// assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface sec_tick_if;
  logic [2:0] trim;
  logic       tick;
  modport gen  (input trim, output tick);
  modport core (output trim, input tick);
endinterface
`default_nettype wire

// *** dv/sec_host.sv ***
// sec_host: host model driving the three-wire port of the counter.
// assumes clk_i is the system clock; serial clock period is 8 clk_i.
`timescale 1ns/1ps
`default_nettype none
module sec_host (
  // system clock, used for pacing and for sampling the line and the device enable
  input  wire logic clk_i,
  // serial port pins
  output logic      port_sel_o,
  output logic      sclk_o,
  output logic      line_o,
  // device data out and enable
  input  wire logic dev_dq_i,
  input  wire logic dev_oe_i
);
  logic host_oe;
  logic host_d;
  logic last_v;
  logic oe_seen;

  // no pull on the line: a floating line shows the inverse of its last value
  assign line_o = dev_oe_i ? dev_dq_i : (host_oe ? host_d : ~last_v);
  always @(posedge clk_i) begin
    last_v <= line_o;
    if (dev_oe_i) oe_seen <= 1'b1;
  end

  initial begin
    port_sel_o = 1'b0;
    sclk_o = 1'b0;
    host_oe = 1'b0;
    host_d = 1'b0;
    last_v = 1'b0;
    oe_seen = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask

  // ncmd below 8 only for a deliberately cut command
  task automatic xfer(input logic [7:0] cmd, input int ncmd, input int ndat,
                      input logic [39:0] wd, output logic [31:0] rd);
    logic rdm;
    rdm = cmd[0] && (cmd[7] ^ cmd[6]);
    rd = '0;
    oe_seen = 1'b0;
    port_sel_o = 1'b1;
    half();
    for (int i = 0; i < ncmd + ndat; i++) begin
      sclk_o = 1'b0;
      host_oe = !(rdm && i >= ncmd);
      if (i < ncmd) host_d = cmd[i];
      else host_d = wd[i-ncmd];
      half();
      // read bit taken off the shared line just before the rise
      if (i >= ncmd && i - ncmd < 32) rd[i-ncmd] = line_o;
      sclk_o = 1'b1;
      half();
    end
    port_sel_o = 1'b0;
    half();
    host_oe = 1'b0;
    sclk_o = 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// *** dv/test_sec_counter.sv ***
// test_sec_counter: self-checking bench for the seconds counter.
// assumes sec_host as far side; one second shortened to 400 clocks.
`timescale 1ns/1ps
`default_nettype none
module test_sec_counter;
  localparam int unsigned SEC_CYC = 400;
  localparam int unsigned STEP    = 10;
  logic clk_i       = 1'b0;
  logic rstn_i      = 1'b0;
  logic supply_ok_i = 1'b1;
  wire logic port_sel;
  wire logic sclk;
  wire logic line;
  wire logic dq_o;
  wire logic dq_oe_o;
  int miscompares = 0;
  int cmp_count   = 0;

  always #20 clk_i = ~clk_i;

  sec_counter #(.SEC_CYCLES(SEC_CYC), .TRIM_STEP(STEP)) sec_counter_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .port_sel_i(port_sel), .sclk_i(sclk),
    .dq_i(line), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .supply_ok_i(supply_ok_i));
  sec_host sec_host_i (
    .clk_i(clk_i), .port_sel_o(port_sel), .sclk_o(sclk), .line_o(line),
    .dev_dq_i(dq_o), .dev_oe_i(dq_oe_o));

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // got minus base must lie in lo..hi; ticks may land mid-sequence
  task automatic near(input string what, input logic [31:0] base,
                      input int lo, input int hi, input logic [31:0] got);
    logic [31:0] d;
    d = got - base;
    cmp_count++;
    if ($isunknown(got) || d < lo || d > hi) begin
      miscompares++;
      $display("[FAIL] %s expected %h+%0d..%0d seen %h", what, base, lo, hi,
               got);
    end
  endtask

  task automatic rd(input logic [7:0] c, output logic [31:0] v);
    sec_host_i.xfer(c, 8, 32, 40'h00_0000_0000, v);
    near("oe during read", 32'h1, 0, 0, 32'(sec_host_i.oe_seen));
    near("oe after deselect", 32'h0, 0, 0, 32'(dq_oe_o));
  endtask

  task automatic wr(input logic [7:0] c, input logic [39:0] w, input int n);
    logic [31:0] d;
    sec_host_i.xfer(c, 8, n, w, d);
  endtask

  initial begin
    logic [31:0] w, a0, p0, a1, p1;
    logic [7:0]  c;
    void'($urandom(29607));
    repeat (10) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    // write with 8 surplus clocks, then read back; all-ones wraps
    for (int k = 0; k < 6; k++) begin
      w = (k < 2) ? 32'hFFFF_FFFF : $urandom;
      c = k[0] ? 8'h40 : 8'h80;
      wr(c, {8'($urandom), w}, 40);
      if (k == 2) sec_host_i.xfer(8'h81, 5, 0, 40'h0, a0);
      rd(c | 8'h01, a1);
      near("read back", w, 0, 1, a1);
    end
    $display("test write_read done");
    // short write leaves the counter alone
    rd(8'h81, a0);
    wr(8'h80, {8'h00, ~a0}, 20);
    rd(8'h81, a1);
    // snapshots 568 clocks apart: one or two ticks land between
    near("short write", a0, 1, 2, a1);
    $display("test short_write done");
    // each clear code
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? 8'h04 : ((k == 1) ? 8'h02 : 8'h06);
      wr(8'h80, 40'h00_8000_0000, 32);
      wr(8'h40, 40'h00_8000_0000, 32);
      wr(c, 40'h0, 0);
      rd(8'h81, a1);
      rd(8'h41, p1);
      near("clear ao", c[2] ? 32'h0 : 32'h8000_0000, 0, 3, a1);
      near("clear pw", c[1] ? 32'h0 : 32'h8000_0000, 0, 3, p1);
    end
    $display("test clear done");
    // trim 000 halts; trailing clocks after trim ignored
    wr(8'hC0, 40'h0, 0);
    rd(8'h41, p0);
    w = $urandom;
    wr(8'h80, {8'h00, w}, 32);
    // trailing clocks would land in the always-on counter if taken
    wr(8'hC0, {8'($urandom), 32'($urandom)}, 32);
    repeat (1200) @(negedge clk_i);
    rd(8'h81, a1);
    rd(8'h41, p1);
    near("stopped ao", w, 0, 0, a1);
    near("stopped pw", p0, 0, 0, p1);
    // top code: 360-clock second over a 4332-clock span
    wr(8'hF8, 40'h0, 0);
    rd(8'h81, a0);
    repeat (4000) @(negedge clk_i);
    rd(8'h81, a1);
    near("fast ao", a0, 12, 13, a1);
    wr(8'hD8, 40'h0, 0);
    $display("test trim done");
    // supply off: port refused, only the always-on counter runs
    rd(8'h81, a0);
    rd(8'h41, p0);
    supply_ok_i = 1'b0;
    wr(8'h80, 40'h0, 32);
    repeat (4000) @(negedge clk_i);
    supply_ok_i = 1'b1;
    repeat (8) @(negedge clk_i);
    rd(8'h81, a1);
    rd(8'h41, p1);
    // 5004 clocks at nominal trim; supply up for about 670 of them
    near("ao while off", a0, 12, 13, a1);
    near("pw while off", p0, 1, 3, p1);
    $display("test supply done");
    close_out();
  end

  // about 23k clocks expected
  initial begin
    repeat (80000) @(posedge clk_i);
    miscompares++;
    $display("[FAIL] watchdog expected end seen hang");
    close_out();
  end
endmodule
`default_nettype wire
